// ===== hdl/dsw_dac_port.sv
`timescale 1ns/100ps
// ============================================================
// Serial DAC write port: link receiver, crossing, DAC state,
// register port
// ============================================================
module dsw_dac_port (
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic [dsw_pkg::ADDR_W-1:0] i_addr,
    input wire logic [dsw_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [dsw_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_sclk,
    input wire logic i_sync_n,
    input wire logic i_din,
    output logic [dsw_pkg::CODE_W-1:0] o_dac_code,
    output logic [dsw_pkg::MODE_W-1:0] o_mode,
    output logic o_amp_on,
    output logic o_pd_1k,
    output logic o_pd_100k,
    output logic o_pd_tristate,
    output logic o_update
);
    import dsw_pkg::*;

    // ============================================================
    // Declarations
    // ============================================================
    // Link capture and crossing
    logic link_rst_ff;
    logic [WORD_W-1:0] link_word;
    logic link_tgl;
    logic [1:0] sync_in;
    logic [1:0] sync_out;
    logic tgl_s;
    logic sync_n_s;
    logic tgl_prev_ff;
    logic new_word;
    logic exec_word;
    logic drop_word;

    // System-side state
    logic ctrl_enable_ff;
    logic [CODE_W-1:0] code_ff;
    logic [MODE_W-1:0] mode_ff;
    logic [WORD_W-1:0] last_word_ff;
    logic [STAT_W-1:0] exec_cnt_ff;
    logic [STAT_W-1:0] drop_cnt_ff;
    logic seen_ff;
    logic update_ff;
    logic amp_on_ff;
    logic pd_1k_ff;
    logic pd_100k_ff;
    logic pd_tri_ff;
    logic [DATA_W-1:0] rdata_ff;

    // Next values and write decodes
    logic [CODE_W-1:0] nxt_code;
    logic [MODE_W-1:0] nxt_mode;
    logic [DATA_W-1:0] nxt_rdata;
    logic wr_ctrl;
    logic wr_status;
    logic wr_exec_cnt;
    logic wr_drop_cnt;

    // ============================================================
    // Link-domain reset
    // ============================================================
    // Registered so the asynchronous clear into the serial-clock side
    // is glitch free; release is asynchronous to the serial clock,
    // which is harmless as long as the host holds the clock still
    // while the system comes out of reset
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            link_rst_ff <= 1'b1;
        end else begin
            link_rst_ff <= 1'b0;
        end
    end

    // ============================================================
    // Serial-clock side
    // ============================================================
    // Everything inside runs on the serial clock; only the word and its
    // toggle leave, and the sync pin enters raw because it is timed
    // against the serial clock, not the system clock
    dsw_link_rx u_link_rx (
        .i_sclk(i_sclk),
        .i_sync_n(i_sync_n),
        .i_din(i_din),
        .i_link_rst(link_rst_ff),
        .o_word(link_word),
        .o_word_tgl(link_tgl)
    );

    // ============================================================
    // Crossing into the system clock
    // ============================================================
    // Toggle carries the word event; sync level is for status only
    // Each bit crosses on its own through two flops; the 16-bit word is
    // never synchronised bit by bit. Limitation: completed words less
    // than about five system clocks apart may overwrite the word before
    // the system side has taken it
    assign sync_in = {i_sync_n, link_tgl};

    dsw_sync2 #(
        .WIDTH(2),
        .RST_VAL(RST_SYNC_BITS)
    ) u_sync (
        .i_clk(i_clk_sys),
        .i_resetn(i_resetn),
        .i_async(sync_in),
        .o_sync(sync_out)
    );

    assign tgl_s = sync_out[0];
    assign sync_n_s = sync_out[1];

    // Previous toggle value tracks the synchronised one through reset
    // so a stale toggle never looks like a fresh word
    // The reset branch deliberately matches the run branch
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            tgl_prev_ff <= tgl_s;
        end else begin
            tgl_prev_ff <= tgl_s;
        end
    end

    // The word register is stable for many serial clocks after the
    // toggle moves, so it is sampled directly once the toggle is seen;
    // one event per toggle change, whichever way it moved
    assign new_word = tgl_s ^ tgl_prev_ff;
    // A disabled port still sees the event, so the drop counter and
    // the last-word register stay truthful for software
    assign exec_word = new_word & ctrl_enable_ff;
    assign drop_word = new_word & ~ctrl_enable_ff;

    // ============================================================
    // Register write decode
    // ============================================================
    // One strobe per writable register; writes to read-only offsets
    // match none of them and are ignored
    assign wr_ctrl = i_wr && (i_addr == OFS_CTRL);
    assign wr_status = i_wr && (i_addr == OFS_STATUS);
    assign wr_exec_cnt = i_wr && (i_addr == OFS_EXEC_CNT);
    assign wr_drop_cnt = i_wr && (i_addr == OFS_DROP_CNT);

    // Port enable: when cleared, completed words are counted but dropped
    // Clearing it mid-frame already affects the word that lands next
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            ctrl_enable_ff <= RST_ENABLE;
        end else if (wr_ctrl) begin
            ctrl_enable_ff <= i_wdata[CTRL_ENABLE_POS];
        end
    end

    // ============================================================
    // DAC register and mode
    // ============================================================
    // Only a completed frame reaches here; interrupted frames never
    // move the toggle, so both fields hold their old values
    // The two leading bits of the word carry nothing and are dropped
    always_comb begin
        nxt_code = code_ff;
        nxt_mode = mode_ff;
        if (exec_word) begin
            nxt_code = link_word[CODE_LSB +: CODE_W];
            nxt_mode = {link_word[MODE_UPPER_POS], link_word[MODE_LOWER_POS]};
        end
    end

    // Power-on value is zero code in normal mode
    // Code and mode move together, at the same edge as the pulse
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            code_ff <= RST_CODE;
            mode_ff <= RST_MODE;
        end else begin
            code_ff <= nxt_code;
            mode_ff <= nxt_mode;
        end
    end

    // Raw word kept for software, ignored leading bits included
    // Kept for dropped words too, so software can see what was refused
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            last_word_ff <= RST_WORD;
        end else if (new_word) begin
            last_word_ff <= link_word;
        end
    end

    // ============================================================
    // Output stage selection from the mode field
    // ============================================================
    // Decoded from the next mode so the selects change with o_mode
    // Exactly one select is high at any time, so the output stage can
    // switch between them without overlap
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            amp_on_ff <= 1'b1;
            pd_1k_ff <= 1'b0;
            pd_100k_ff <= 1'b0;
            pd_tri_ff <= 1'b0;
        end else begin
            amp_on_ff <= (nxt_mode == MODE_NORMAL);
            pd_1k_ff <= (nxt_mode == MODE_PD_1K);
            pd_100k_ff <= (nxt_mode == MODE_PD_100K);
            pd_tri_ff <= (nxt_mode == MODE_PD_TRI);
        end
    end

    // One-cycle pulse marking each executed word
    // Dropped words raise no pulse, since nothing downstream changed
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            update_ff <= 1'b0;
        end else begin
            update_ff <= exec_word;
        end
    end

    // ============================================================
    // Status and counters
    // ============================================================
    // Sticky word-seen flag, write one to clear; an executed word in the
    // same cycle as the clear keeps it set
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            seen_ff <= 1'b0;
        end else if (exec_word) begin
            seen_ff <= 1'b1;
        end else if (wr_status && i_wdata[STAT_SEEN_POS]) begin
            seen_ff <= 1'b0;
        end
    end

    // Executed-word counter, any write clears, a count wins over it
    // Both counters wrap at 16 bits; software polling less often than
    // every 65536 words loses the carry
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            exec_cnt_ff <= '0;
        end else if (exec_word) begin
            if (wr_exec_cnt) begin
                exec_cnt_ff <= 16'h0001;
            end else begin
                exec_cnt_ff <= exec_cnt_ff + 16'h0001;
            end
        end else if (wr_exec_cnt) begin
            exec_cnt_ff <= '0;
        end
    end

    // Dropped-word counter for words arriving while disabled
    // Same set-wins ordering as the executed counter
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            drop_cnt_ff <= '0;
        end else if (drop_word) begin
            if (wr_drop_cnt) begin
                drop_cnt_ff <= 16'h0001;
            end else begin
                drop_cnt_ff <= drop_cnt_ff + 16'h0001;
            end
        end else if (wr_drop_cnt) begin
            drop_cnt_ff <= '0;
        end
    end

    // ============================================================
    // Register read
    // ============================================================
    // Data stands only in the cycle after the read strobe; unmapped
    // offsets read as zero; status is bit 0 word seen, bit 1 frame open,
    // bit 2 powered down; reading never clears anything
    always_comb begin
        nxt_rdata = '0;
        if (i_rd) begin
            case (i_addr)
                OFS_CODE: begin
                    nxt_rdata = {20'h00000, code_ff};
                end
                OFS_MODE: begin
                    nxt_rdata = {30'h0, mode_ff};
                end
                OFS_CTRL: begin
                    nxt_rdata = {31'h0, ctrl_enable_ff};
                end
                OFS_STATUS: begin
                    nxt_rdata = {29'h0, ~amp_on_ff, ~sync_n_s, seen_ff};
                end
                OFS_EXEC_CNT: begin
                    nxt_rdata = {16'h0000, exec_cnt_ff};
                end
                OFS_DROP_CNT: begin
                    nxt_rdata = {16'h0000, drop_cnt_ff};
                end
                OFS_LAST_WORD: begin
                    nxt_rdata = {16'h0000, last_word_ff};
                end
                default: begin
                    nxt_rdata = '0;
                end
            endcase
        end
    end

    // Read answer register, zero whenever no read was asked
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    // All straight from flops, so nothing downstream sees decode glitches
    assign o_rdata = rdata_ff;
    assign o_dac_code = code_ff;
    assign o_mode = mode_ff;
    assign o_amp_on = amp_on_ff;
    assign o_pd_1k = pd_1k_ff;
    assign o_pd_100k = pd_100k_ff;
    assign o_pd_tristate = pd_tri_ff;
    assign o_update = update_ff;

endmodule : dsw_dac_port

// ===== hdl/dsw_link_rx.sv
`timescale 1ns/100ps
// ============================================================
// Serial-clock side: frame shifter and word hand-off
// ============================================================
module dsw_link_rx (
    input wire logic i_sclk,
    input wire logic i_sync_n,
    input wire logic i_din,
    input wire logic i_link_rst,
    output logic [dsw_pkg::WORD_W-1:0] o_word,
    output logic o_word_tgl
);
    import dsw_pkg::*;

    logic [WORD_W-1:0] shift_ff;
    logic [CNT_W-1:0] bit_cnt_ff;
    logic [WORD_W-1:0] word_ff;
    logic word_tgl_ff;
    logic frame_clr;

    // The serial clock may stop outside frames, so the frame is ended
    // by the sync line itself rather than by a later clock edge
    assign frame_clr = i_sync_n | i_link_rst;

    // Shift on falling edges while the frame is open
    always_ff @(negedge i_sclk or posedge frame_clr) begin
        if (frame_clr) begin
            shift_ff <= RST_WORD;
            bit_cnt_ff <= '0;
        end else if (bit_cnt_ff != FULL_CNT) begin
            shift_ff <= {shift_ff[WORD_W-2:0], i_din};
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
        end
        // After the full count, edges are ignored until sync goes high
    end

    // Complete word is latched on the 16th edge and flagged by a toggle
    always_ff @(negedge i_sclk or posedge i_link_rst) begin
        if (i_link_rst) begin
            word_ff <= RST_WORD;
            word_tgl_ff <= 1'b0;
        end else if (!i_sync_n && bit_cnt_ff == LAST_BIT_CNT) begin
            word_ff <= {shift_ff[WORD_W-2:0], i_din};
            word_tgl_ff <= ~word_tgl_ff;
        end
    end

    assign o_word = word_ff;
    assign o_word_tgl = word_tgl_ff;

endmodule : dsw_link_rx

// ===== hdl/dsw_pkg.sv
// ============================================================
// Shared constants for the serial DAC write port
// ============================================================
package dsw_pkg;

    // ============================================================
    // Serial word layout
    // ============================================================
    localparam int WORD_W = 16;
    localparam int CODE_W = 12;
    localparam int MODE_W = 2;
    localparam int CNT_W = 5;
    localparam logic [4:0] LAST_BIT_CNT = 5'h0f;
    localparam logic [4:0] FULL_CNT = 5'h10;
    localparam int CODE_LSB = 0;
    localparam int MODE_LOWER_POS = 12;
    localparam int MODE_UPPER_POS = 13;

    // ============================================================
    // Operating modes carried in the mode field
    // ============================================================
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PD_1K = 2'h1;
    localparam logic [1:0] MODE_PD_100K = 2'h2;
    localparam logic [1:0] MODE_PD_TRI = 2'h3;

    // ============================================================
    // Register port
    // ============================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STAT_W = 16;
    localparam logic [7:0] OFS_CODE = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_EXEC_CNT = 8'h10;
    localparam logic [7:0] OFS_DROP_CNT = 8'h14;
    localparam logic [7:0] OFS_LAST_WORD = 8'h18;
    localparam int CTRL_ENABLE_POS = 0;
    localparam int STAT_SEEN_POS = 0;
    localparam int STAT_FRAME_POS = 1;
    localparam int STAT_PD_POS = 2;

    // ============================================================
    // Reset values
    // ============================================================
    localparam logic [11:0] RST_CODE = 12'h000;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic RST_ENABLE = 1'b1;
    localparam logic [1:0] RST_SYNC_BITS = 2'h2;

endpackage : dsw_pkg

// ===== hdl/dsw_sync2.sv
`timescale 1ns/100ps
// ============================================================
// Two-flop level synchroniser, one stage pair per bit
// ============================================================
module dsw_sync2 #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    import dsw_pkg::*;

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage is read only by the second stage
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule : dsw_sync2

// ===== tb/dsw_dac_port_asserts.sv
`timescale 1ns/100ps
// ============================================================
// Port checks for the serial DAC write port
// ============================================================
module dsw_dac_port_asserts
    import dsw_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_rd,
    input wire logic i_sync_n,
    input wire logic [dsw_pkg::DATA_W-1:0] o_rdata,
    input wire logic [dsw_pkg::CODE_W-1:0] o_dac_code,
    input wire logic [dsw_pkg::MODE_W-1:0] o_mode,
    input wire logic o_amp_on,
    input wire logic o_pd_1k,
    input wire logic o_pd_100k,
    input wire logic o_pd_tristate,
    input wire logic o_update
);
    logic [3:0] low_age_ff;

    default clocking cb @(posedge i_clk_sys); endclocking

    // Cycles since sync was seen low; saturates so long idle never wraps
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || !i_sync_n) begin
            low_age_ff <= 4'h0;
        end else if (low_age_ff != 4'hf) begin
            low_age_ff <= low_age_ff + 4'h1;
        end
    end

    // Words come at least five cycles apart, so a pulse stands alone
    sequence s_update_pulse;
        o_update ##1 !o_update [*3];
    endsequence

    a_update_pulse: assert property (disable iff (!i_resetn) o_update |-> s_update_pulse)
        else $error("update pulse too long or repeated");
    a_code_hold: assert property (disable iff (!i_resetn) !o_update |-> $stable(o_dac_code))
        else $error("code moved without update");
    a_mode_hold: assert property (disable iff (!i_resetn) !o_update |-> $stable(o_mode))
        else $error("mode moved without update");
    a_amp_decode: assert property (disable iff (!i_resetn) o_amp_on == (o_mode == MODE_NORMAL))
        else $error("amplifier enable disagrees with mode");
    a_pd_decode: assert property (disable iff (!i_resetn)
        {o_pd_1k, o_pd_100k, o_pd_tristate} ==
        {o_mode == MODE_PD_1K, o_mode == MODE_PD_100K, o_mode == MODE_PD_TRI})
        else $error("power-down selects disagree with mode");
    a_reset_zero: assert property (!i_resetn |=> o_dac_code == RST_CODE && o_mode == RST_MODE)
        else $error("reset did not clear code and mode");
    a_update_frame: assert property (disable iff (!i_resetn) o_update |-> low_age_ff <= 4'h6)
        else $error("update without a recent frame");
    a_rdata_idle: assert property (disable iff (!i_resetn) !i_rd |=> o_rdata == '0)
        else $error("read data outside read answer");
    c_tristate: cover property (o_update && o_mode == MODE_PD_TRI);
endmodule : dsw_dac_port_asserts

bind dsw_dac_port dsw_dac_port_asserts u_asserts (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_rd(i_rd), .i_sync_n(i_sync_n), .o_rdata(o_rdata), .o_dac_code(o_dac_code),
    .o_mode(o_mode), .o_amp_on(o_amp_on), .o_pd_1k(o_pd_1k), .o_pd_100k(o_pd_100k),
    .o_pd_tristate(o_pd_tristate), .o_update(o_update));

// ===== tb/dsw_host_model.sv
`timescale 1ns/100ps
// ============================================================
// Host serial master: 15 ns clock, still between frames
// ============================================================
module dsw_host_model (
    output logic o_sclk,
    output logic o_sync_n,
    output logic o_din
);
    localparam realtime HALF = 7.5;

    initial begin
        o_sclk = 1'b0;
        o_sync_n = 1'b1;
        o_din = 1'b1;
    end

    // Fewer than 16 edges aborts; extra edges carry the inverted word
    task automatic frame(input logic [15:0] w, input int n);
        logic [31:0] bits;
        bits = {w, ~w};
        #3.3;
        o_sync_n = 1'b0; // Frame opens low
        #HALF;
        for (int i = 0; i < n; i++) begin
            o_sclk = 1'b1;
            o_din = bits[31-i]; // Most significant first
            #HALF;
            o_sclk = 1'b0;
            #HALF;
        end
        #HALF;
        o_sync_n = 1'b1; // Frame closes, held high past minimum
        o_din = ~o_din; // Released line must not look stable
        #45;
    endtask : frame
endmodule : dsw_host_model

// ===== tb/test_dac_serial_write_port.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
// ============================================================
// Bench: host frames against a queue model of executed words
// ============================================================
module test_dac_serial_write_port;
    import dsw_pkg::*;
    logic i_clk_sys, i_resetn, i_wr, i_rd, i_sclk, i_sync_n, i_din;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, d;
    logic [11:0] o_dac_code, exp_code, code;
    logic [1:0] o_mode, exp_mode;
    logic o_amp_on, o_pd_1k, o_pd_100k, o_pd_tristate, o_update;
    logic [15:0] w, m;
    logic [15:0] exp_q[$];
    int err_total = 0;
    int tests_run = 0;
    int enable = 1;
    int rnd;

    dsw_dac_port dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sclk(i_sclk),
        .i_sync_n(i_sync_n), .i_din(i_din), .o_dac_code(o_dac_code), .o_mode(o_mode),
        .o_amp_on(o_amp_on), .o_pd_1k(o_pd_1k), .o_pd_100k(o_pd_100k),
        .o_pd_tristate(o_pd_tristate), .o_update(o_update));
    dsw_host_model u_host (.o_sclk(i_sclk), .o_sync_n(i_sync_n), .o_din(i_din));

    // System clock, 100 ns
    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    // An update with nothing expected compares against unknowns and fails
    always @(posedge i_clk_sys) begin
        if (o_update === 1'b1) begin
            m = (exp_q.size() != 0) ? exp_q.pop_front() : 16'hxxxx;
            `CHK(o_dac_code, m[11:0]); // Code executed at edge 16
            `CHK(o_mode, m[13:12]); // Mode field position
            `CHK({o_amp_on, o_pd_1k, o_pd_100k, o_pd_tristate}, 4'h8 >> m[13:12]); // Selects
            exp_code = m[11:0];
            exp_mode = m[13:12];
        end
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : bus_wr

    // Read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        @(posedge i_clk_sys);
        v = o_rdata;
    endtask : bus_rd

    // Bounded wait for the model to drain, then spacing past 500 ns
    task automatic send(input logic [15:0] wv, input int n);
        int k;
        if (n >= 16 && enable == 1) exp_q.push_back(wv);
        u_host.frame(wv, n);
        k = 0;
        while (exp_q.size() != 0 && k < 20) begin
            @(posedge i_clk_sys);
            k++;
        end
        if (exp_q.size() != 0) begin
            err_total++;
            wrap_up();
        end
        repeat (6) @(posedge i_clk_sys);
    endtask : send

    initial begin
        i_resetn = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        exp_code = RST_CODE;
        exp_mode = RST_MODE;
        rnd = $urandom(628);
        repeat (4) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        `CHK({o_dac_code, o_mode, o_amp_on}, 15'h0001); // Zero at power-up
        // Every mode twice, boundary codes first, one frame with extra edges
        for (int i = 0; i < 8; i++) begin
            code = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($urandom);
            w = {2'($urandom), 2'(i), code};
            send(w, (i == 5) ? 20 : 16); // Late edges ignored
            bus_rd(OFS_CODE, d);
            `CHK(d, {20'h0, exp_code}); // Code readback
            bus_rd(OFS_MODE, d);
            `CHK(d, {30'h0, exp_mode}); // Mode readback
        end
        // Aborts after 1, 8 and 15 edges leave everything alone
        for (int n = 1; n < 16; n += 7) begin
            send(16'($urandom), n); // Partial word dropped
            `CHK({o_dac_code, o_mode}, {exp_code, exp_mode}); // Nothing changed
        end
        bus_rd(OFS_EXEC_CNT, d);
        `CHK(d, 32'h8); // Aborts not counted
        bus_wr(OFS_EXEC_CNT, 32'h0);
        bus_rd(OFS_EXEC_CNT, d);
        `CHK(d, 32'h0);
        // Disabled port drops a complete word but records it
        bus_wr(OFS_CTRL, 32'h0);
        enable = 0;
        w = {4'h1, 12'($urandom)};
        send(w, 16);
        `CHK({o_dac_code, o_mode}, {exp_code, exp_mode});
        bus_rd(OFS_DROP_CNT, d);
        `CHK(d, 32'h1);
        bus_rd(OFS_LAST_WORD, d);
        `CHK(d, {16'h0, w});
        bus_rd(8'h20, d);
        `CHK(d, 32'h0);
        // Mid-run reset restores zero code and enable
        @(posedge i_clk_sys);
        i_resetn <= 1'b0;
        repeat (4) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        `CHK({o_dac_code, o_mode}, 14'h0); // Zero after reset
        enable = 1;
        bus_rd(OFS_CTRL, d);
        `CHK(d, 32'h1);
        send(16'h3abc, 16); // Tristate after reset
        bus_rd(OFS_STATUS, d);
        `CHK(d, 32'h5); // Seen, no frame, powered down
        bus_wr(OFS_STATUS, 32'h1);
        bus_rd(OFS_STATUS, d);
        `CHK(d, 32'h4); // Seen cleared, still powered down
        wrap_up();
    end

    // Cuts a hang short
    initial begin
        #200000;
        err_total++;
        wrap_up();
    end
endmodule : test_dac_serial_write_port
